//--- hw/drive_mode_pkg.sv
// Package for the drive control mode selector: register map, fields,
// reset values, timing constants and carrier structs.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
`default_nettype none
package drive_mode_pkg;
    // Register byte offsets
    localparam logic [7:0] CfgOffs     = 8'h00;
    localparam logic [7:0] MinFreqOffs = 8'h04;
    localparam logic [7:0] RampOffs    = 8'h08;
    localparam logic [7:0] VariantOffs = 8'h0c;
    localparam logic [7:0] StatusOffs  = 8'h10;
    localparam logic [7:0] IrqStatOffs = 8'h14;
    localparam logic [7:0] IrqMaskOffs = 8'h18;
    localparam logic [7:0] SensorOffs  = 8'h1c;
    // Reset values
    localparam logic [2:0] CfgReset      = 3'h0;
    localparam logic [7:0] MinFreqReset  = 8'h1e;   // 30 Hz
    localparam logic [7:0] MinFreqFloor  = 8'h05;   // 5 Hz
    localparam logic [7:0] StartRampSec  = 8'h08;   // 8 s
    localparam logic [7:0] StopRampSec   = 8'h08;
    localparam logic       FreewheelReset = 1'b1;
    // Ramp field positions
    localparam int StartRampLsb = 0;
    localparam int StopRampLsb  = 8;
    localparam int FreewheelBit = 16;
    // Interrupt event bits
    localparam int EvCfgChange = 0;
    localparam int EvFailover  = 1;
    localparam int EvRunChange = 2;
    localparam int EvCount     = 3;
    // Contact debounce: 10 ms
    localparam int ClkMhz        = 100;
    localparam int DebounceUs    = 10000;
    localparam int DebounceCycles = DebounceUs * ClkMhz;
    // Analog reference scale: 12-bit codes, full scale maps to max freq
    localparam int AdcBits = 12;
    localparam logic [11:0] LoopZeroCode = 12'h333; // 4 mA of 20 mA

    typedef enum logic [2:0] {
        CfgBasicRun, CfgDigitalCp, CfgAnalogCp, CfgRedundantCp,
        CfgDualCp, CfgVoltSpeed, CfgLoopSpeed, CfgHandOffAuto
    } sys_cfg_t;

    typedef struct packed {
        logic first;
        logic second;
        logic third;
        logic fourth;
    } contacts_t;

    typedef struct packed {
        logic       runPermit;
        logic       pressureMode;
        logic       speedMode;
        logic       useSecondary;
        logic [1:0] setpointSel;
        logic       precharge;
        logic       leadLag;
    } mode_out_t;

    typedef struct packed {
        logic [7:0] startRamp;
        logic [7:0] stopRamp;
        logic       freewheel;
    } ramp_cfg_t;
endpackage
`default_nettype wire

//--- hw/drive_control_mode_selector.sv
// Drive control mode selector: interprets contacts and analog references
// per configuration code, exposes registers over AXI4-Lite.
// Assumes contacts and analog codes are synchronous to clk.
//
// Notes on behaviour
// - Code 0..7 picks run/stop, pressure, speed or hand/off/auto mode.
// - Code 0 runs only with first and second contacts closed.
// - Code 3 fails over to backup sensor when primary fails.
// - Code 3 four-setpoint: third/fourth contacts pick setpoint 1..4.
// - Code 3 four-setpoint needs contacts 1 and 2; two-setpoint only 1.
// - Code 3 two-setpoint: second contact picks setpoint 1 or 2.
// - Code 4 first contact is run/stop.
// - Code 4 second contact selects secondary sensor and second setpoint.
// - Code 5 speed from voltage, ignored below minimum speed, 5 Hz floor.
// - Codes 5 and 6 run only with first and second contacts closed.
// - Code 6 speed linear from loop current, no pressure regulation.
// - Code 7 first contact open stops, closed allows running.
// - Code 7 third open: pressure control; closed: potentiometer speed.
// - Code 7 second contact needed in auto, ignored in hand.
// - Pre-charge and lead/lag enabled only in pressure modes.
// - Ramp times span lowest to highest frequency and reverse.
// - Start ramp defaults to 8 s; freewheel stop on by default.
`default_nettype none
module drive_control_mode_selector
    import drive_mode_pkg::*;
#(
    parameter int DebounceLen = drive_mode_pkg::DebounceCycles,
    parameter int MaxFreqHz   = 60
) (
    input  wire logic                      clk,          // 100 MHz clock
    input  wire logic                      nrst,         // Async reset
    input  wire drive_mode_pkg::contacts_t contactsRaw,  // Dry contacts
    input  wire logic [11:0]               voltRef,      // 0-5 V code
    input  wire logic [11:0]               loopRef,      // Primary loop code
    input  wire logic                      primaryFail,  // Primary sensor bad
    input  wire logic [31:0]               s_axi_awaddr, // Write address
    input  wire logic                      s_axi_awvalid,// Write addr valid
    output logic                           s_axi_awready,// Write addr ready
    input  wire logic [31:0]               s_axi_wdata,  // Write data
    input  wire logic [3:0]                s_axi_wstrb,  // Byte strobes
    input  wire logic                      s_axi_wvalid, // Write data valid
    output logic                           s_axi_wready, // Write data ready
    output logic [1:0]                     s_axi_bresp,  // Write response
    output logic                           s_axi_bvalid, // Response valid
    input  wire logic                      s_axi_bready, // Response ready
    input  wire logic [31:0]               s_axi_araddr, // Read address
    input  wire logic                      s_axi_arvalid,// Read addr valid
    output logic                           s_axi_arready,// Read addr ready
    output logic [31:0]                    s_axi_rdata,  // Read data
    output logic [1:0]                     s_axi_rresp,  // Read response
    output logic                           s_axi_rvalid, // Read data valid
    input  wire logic                      s_axi_rready, // Read data ready
    output drive_mode_pkg::mode_out_t      modeOut,      // Mode decisions
    output drive_mode_pkg::ramp_cfg_t      rampOut,      // Ramp settings
    output logic [7:0]                     speedHz,      // Speed command
    output logic                           irq           // Interrupt level
);
    import drive_mode_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Contact synchronisers and debouncers
    logic [3:0]  syncA_q, syncB_q, stable_q;
    logic [31:0] dbCnt_q [4];
    contacts_t   ct;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncA_q <= 4'h0;
            syncB_q <= 4'h0;
        end else begin
            syncA_q <= contactsRaw;
            syncB_q <= syncA_q;
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_db
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                dbCnt_q[i]  <= 32'h0;
                stable_q[i] <= 1'b0;
            end else if (syncB_q[i] == stable_q[i]) begin
                dbCnt_q[i] <= 32'h0;
            end else if (dbCnt_q[i] >= 32'(DebounceLen - 1)) begin
                dbCnt_q[i]  <= 32'h0;
                stable_q[i] <= syncB_q[i];
            end else begin
                dbCnt_q[i] <= dbCnt_q[i] + 32'h1;
            end
        end
    end
    assign ct = contacts_t'(stable_q);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [2:0]  cfg_q;
    logic [7:0]  minFreq_q;
    ramp_cfg_t   ramp_q;
    logic        fourSp_q;
    logic        failed_q;
    logic [EvCount-1:0] irqStat_q, irqMask_q, ev;
    sys_cfg_t    cfg;
    assign cfg = sys_cfg_t'(cfg_q);

    // Write channel: accept address and data in either order
    logic        awHeld_q, wHeld_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        doWrite, wrOk;

    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h0;
            wData_q  <= 32'h0;
            wStrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr[7:0];
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    function automatic logic mapped(input logic [7:0] a);
        mapped = a inside {CfgOffs, MinFreqOffs, RampOffs, VariantOffs,
                           StatusOffs, IrqStatOffs, IrqMaskOffs, SensorOffs};
    endfunction

    assign wrOk = mapped(awAddr_q);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrOk ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q     <= CfgReset;
            minFreq_q <= MinFreqReset;
            ramp_q    <= '{StartRampSec, StopRampSec, FreewheelReset};
            fourSp_q  <= 1'b1;
            irqMask_q <= '0;
        end else if (doWrite && wStrb_q[0]) begin
            unique case (awAddr_q)
                CfgOffs:     cfg_q <= wData_q[2:0];
                MinFreqOffs: minFreq_q <= (wData_q[7:0] < MinFreqFloor)
                                 ? MinFreqFloor : wData_q[7:0];
                RampOffs: begin
                    ramp_q.startRamp <= wData_q[StartRampLsb +: 8];
                    if (wStrb_q[1])
                        ramp_q.stopRamp <= wData_q[StopRampLsb +: 8];
                    if (wStrb_q[2])
                        ramp_q.freewheel <= wData_q[FreewheelBit];
                end
                VariantOffs: fourSp_q  <= wData_q[0];
                IrqMaskOffs: irqMask_q <= wData_q[EvCount-1:0];
                default: ;
            endcase
        end
    end
    assign rampOut = ramp_q;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    mode_out_t mo_d, mo_q;
    logic [7:0] speed_d, speed_q;

    function automatic logic [7:0] scaleRef(input logic [11:0] code,
                                            input logic [11:0] zero);
        logic [11:0] span;
        logic [23:0] prod;
        span = (code > zero) ? code - zero : 12'h0;
        prod = 24'(span) * 24'(MaxFreqHz);
        scaleRef = 8'(prod / 24'(12'hfff - zero));
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) failed_q <= 1'b0;
        else       failed_q <= primaryFail && cfg == CfgRedundantCp;
    end

    always_comb begin
        logic [7:0] ref8;
        ref8 = 8'h0;
        mo_d = '0;
        speed_d = 8'h0;
        unique case (cfg)
            CfgBasicRun: mo_d.runPermit = ct.first && ct.second;
            CfgDigitalCp, CfgAnalogCp: begin
                mo_d.runPermit = ct.first && ct.second;
                mo_d.pressureMode = 1'b1;
            end
            CfgRedundantCp: begin
                mo_d.pressureMode = 1'b1;
                mo_d.useSecondary = failed_q;
                if (fourSp_q) begin
                    mo_d.runPermit = ct.first && ct.second;
                    mo_d.setpointSel = {ct.fourth, ct.third};
                end else begin
                    mo_d.runPermit = ct.first;
                    mo_d.setpointSel = {1'b0, ct.second};
                end
            end
            CfgDualCp: begin
                mo_d.pressureMode = 1'b1;
                mo_d.runPermit = ct.first;
                mo_d.useSecondary = ct.second;
                mo_d.setpointSel = {1'b0, ct.second};
            end
            CfgVoltSpeed, CfgLoopSpeed: begin
                mo_d.speedMode = 1'b1;
                ref8 = (cfg == CfgVoltSpeed) ? scaleRef(voltRef, 12'h0)
                                             : scaleRef(loopRef, LoopZeroCode);
                speed_d = (ref8 >= minFreq_q) ? ref8 : 8'h0;
                mo_d.runPermit = ct.first && ct.second;
            end
            CfgHandOffAuto: begin
                if (ct.third) begin
                    mo_d.speedMode = 1'b1;
                    ref8 = scaleRef(voltRef, 12'h0);
                    speed_d = (ref8 >= minFreq_q) ? ref8 : 8'h0;
                    mo_d.runPermit = ct.first;
                end else begin
                    mo_d.pressureMode = 1'b1;
                    mo_d.runPermit = ct.first && ct.second;
                end
            end
        endcase
        mo_d.precharge = mo_d.pressureMode;
        mo_d.leadLag   = mo_d.pressureMode;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mo_q    <= '0;
            speed_q <= 8'h0;
        end else begin
            mo_q    <= mo_d;
            speed_q <= speed_d;
        end
    end
    assign modeOut = mo_q;
    assign speedHz = speed_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over write-one-to-clear
    logic [2:0] cfgPrev_q;
    logic       clrW;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cfgPrev_q <= CfgReset;
        else       cfgPrev_q <= cfg_q;
    end
    assign ev[EvCfgChange] = cfgPrev_q != cfg_q;
    assign ev[EvFailover]  = mo_d.useSecondary && !mo_q.useSecondary
                             && cfg == CfgRedundantCp;
    assign ev[EvRunChange] = mo_d.runPermit != mo_q.runPermit;
    assign clrW = doWrite && wStrb_q[0] && awAddr_q == IrqStatOffs;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) irqStat_q <= '0;
        else irqStat_q <= (irqStat_q & ~(clrW ? wData_q[EvCount-1:0] : '0))
                          | ev;
    end
    assign irq = |(irqStat_q & irqMask_q);

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr[7:0]) ? 2'h0 : 2'h2;
            unique case (s_axi_araddr[7:0])
                CfgOffs:     s_axi_rdata <= {29'h0, cfg_q};
                MinFreqOffs: s_axi_rdata <= {24'h0, minFreq_q};
                RampOffs:    s_axi_rdata <= {15'h0, ramp_q.freewheel,
                                             ramp_q.stopRamp, ramp_q.startRamp};
                VariantOffs: s_axi_rdata <= {31'h0, fourSp_q};
                StatusOffs:  s_axi_rdata <= {16'h0, speed_q, mo_q};
                IrqStatOffs: s_axi_rdata <= {29'h0, irqStat_q};
                IrqMaskOffs: s_axi_rdata <= {29'h0, irqMask_q};
                SensorOffs:  s_axi_rdata <= {27'h0, failed_q, stable_q};
                default:     s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    basic_run_a: assert property (@(posedge clk) disable iff (!nrst)
        cfg == CfgBasicRun && !(ct.first && ct.second) |=> !modeOut.runPermit)
        else $error("basic mode ran with a contact open");
    dual_sel_a: assert property (@(posedge clk) disable iff (!nrst)
        cfg == CfgDualCp && $stable(cfg) |=> modeOut.useSecondary == $past(ct.second))
        else $error("dual sensor choice wrong");
    sp_four_a: assert property (@(posedge clk) disable iff (!nrst)
        cfg == CfgRedundantCp && fourSp_q |=>
        modeOut.setpointSel == {$past(ct.fourth), $past(ct.third)})
        else $error("setpoint decode wrong");
    speed_min_a: assert property (@(posedge clk) disable iff (!nrst)
        speedHz != 8'h0 |-> speedHz >= minFreq_q || $changed(minFreq_q))
        else $error("speed below minimum");
    loop_nopress_a: assert property (@(posedge clk) disable iff (!nrst)
        cfg == CfgLoopSpeed |=> !modeOut.pressureMode)
        else $error("pressure mode in speed config");
    hoa_off_a: assert property (@(posedge clk) disable iff (!nrst)
        cfg == CfgHandOffAuto && !ct.first |=> !modeOut.runPermit)
        else $error("ran with switch off");
    precharge_a: assert property (@(posedge clk) disable iff (!nrst)
        modeOut.precharge || modeOut.leadLag |->
        !($past(cfg) inside {CfgBasicRun, CfgVoltSpeed, CfgLoopSpeed}))
        else $error("precharge outside pressure mode");
    minfloor_a: assert property (@(posedge clk) disable iff (!nrst)
        minFreq_q >= MinFreqFloor)
        else $error("minimum speed below floor");
endmodule // drive_control_mode_selector
`default_nettype wire

//--- tb/contact_field_model.sv
// Field model: bouncing dry contacts and transducer codes.
// Assumes the bench sets its wanted levels just after a clock edge.
`default_nettype none
module contact_field_model
    import drive_mode_pkg::*;
(
    input  wire logic                      clk,          // Clock
    input  wire logic                      nrst,         // Async reset
    input  wire drive_mode_pkg::contacts_t wantContacts, // Target levels
    input  wire logic [11:0]               wantVolt,     // Pot code
    input  wire logic [11:0]               wantLoop,     // Loop code
    input  wire logic                      wantFail,     // Sensor broken
    output var  drive_mode_pkg::contacts_t contactsRaw,  // Contact pins
    output var  logic [11:0]               voltRef,      // Pot level
    output var  logic [11:0]               loopRef,      // Loop level
    output var  logic                      primaryFail   // Fault level
);
    timeunit 1ns;
    timeprecision 1ps;
    contacts_t  heldQ, flipQ;
    logic [1:0] bounceQ;

    // A changed contact chatters for three cycles before it settles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            heldQ   <= '0;
            flipQ   <= '0;
            bounceQ <= 2'h0;
        end else if (wantContacts != heldQ) begin
            heldQ   <= wantContacts;
            flipQ   <= wantContacts ^ heldQ;
            bounceQ <= 2'h3;
        end else if (bounceQ != 2'h0) begin
            bounceQ <= bounceQ - 2'h1;
        end
    end
    assign contactsRaw = heldQ ^ (flipQ & {4{bounceQ[0]}});

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            voltRef     <= 12'h000;
            loopRef     <= 12'h000;
            primaryFail <= 1'b0;
        end else begin
            voltRef     <= wantVolt;
            loopRef     <= wantLoop;
            primaryFail <= wantFail;
        end
    end
endmodule // contact_field_model
`default_nettype wire

//--- tb/tb_top.sv
// Bench for the drive control mode selector: register map, debounce,
// random mode decisions, speed references and the interrupt.
// Assumes the package, the design and the field model compile first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import drive_mode_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    contacts_t   want, contactsRaw;
    logic [11:0] wantVolt, wantLoop, voltRef, loopRef;
    logic        wantFail, primaryFail, irq;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    mode_out_t   modeOut;
    ramp_cfg_t   rampOut;
    logic [7:0]  speedHz;
    int          n_errors = 0, samples_checked = 0;
    int          seed = 7;
    logic [11:0] refs [4] = '{12'h000, 12'h400, 12'hc00, 12'hfff};

    always #5 clk = ~clk;

    contact_field_model field_u (.clk(clk), .nrst(nrst),
        .wantContacts(want), .wantVolt(wantVolt), .wantLoop(wantLoop),
        .wantFail(wantFail), .contactsRaw(contactsRaw),
        .voltRef(voltRef), .loopRef(loopRef), .primaryFail(primaryFail));

    drive_control_mode_selector #(.DebounceLen(4), .MaxFreqHz(60)) dut_u (
        .clk(clk), .nrst(nrst), .contactsRaw(contactsRaw),
        .voltRef(voltRef), .loopRef(loopRef), .primaryFail(primaryFail),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .modeOut(modeOut),
        .rampOut(rampOut), .speedHz(speedHz), .irq(irq));

    ////////////////////////////////////////////////////////////////////
    function automatic mode_out_t expMode(logic [2:0] c, contacts_t k,
                                          logic four, logic f);
        mode_out_t m;
        m = '0;
        m.runPermit = k.first & k.second;
        if (c == 3'h3) begin
            m.runPermit    = four ? k.first & k.second : k.first;
            m.useSecondary = f;
            m.setpointSel  = four ? {k.fourth, k.third} : {1'b0, k.second};
        end
        if (c == 3'h4) begin
            m.runPermit    = k.first;
            m.useSecondary = k.second;
            m.setpointSel  = {1'b0, k.second};
        end
        if (c == 3'h7 && k.third) m.runPermit = k.first;
        m.pressureMode = (c inside {[3'h1:3'h4]}) || (c == 3'h7 && !k.third);
        m.speedMode    = (c == 3'h5) || (c == 3'h6) || (c == 3'h7 && k.third);
        m.precharge    = m.pressureMode;
        m.leadLag      = m.pressureMode;
        return m;
    endfunction

    function automatic logic [7:0] expSpeed(logic [2:0] c, logic [11:0] v,
                                            logic [7:0] mn);
        int f;
        f = 0;
        if (c == 3'h5 || c == 3'h7) f = v * 60 / 4095;
        if (c == 3'h6 && v > 12'h333) f = (v - 12'h333) * 60 / 3276;
        if (f < mn) f = 0;
        return f[7:0];
    endfunction

    task automatic chkVal(string what, logic [31:0] e, logic [31:0] o);
        samples_checked++;
        if (o !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, o);
        end
    endtask

    // One hertz of slack for rounding
    task automatic chkNear(string what, logic [7:0] e, logic [7:0] o);
        samples_checked++;
        if ($isunknown(o) || {1'b0, o} > {1'b0, e} + 9'd1 ||
            {1'b0, o} + 9'd1 < {1'b0, e}) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, o);
        end
    endtask

    task automatic axWr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
        int t = 0;
        @(posedge clk);
        r = 2'h3;
        awaddr  <= {24'h0, a};
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (t < 100) begin
            @(posedge clk);
            t++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                t = 999;
            end
        end
        if (t != 999) n_errors++;
    endtask

    task automatic axRd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
        int t = 0;
        @(posedge clk);
        r = 2'h3;
        d = '0;
        araddr  <= {24'h0, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (t < 100) begin
            @(posedge clk);
            t++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                t = 999;
            end
        end
        if (t != 999) n_errors++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axWr(a, d, r);
        chkVal("bresp", 32'h0, 32'(r));
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [1:0] er,
                         input logic [31:0] ed);
        logic [31:0] d;
        logic [1:0]  r;
        axRd(a, d, r);
        chkVal("rresp", 32'(er), 32'(r));
        chkVal("rdata", ed, d);
    endtask

    task automatic modeCase(input logic [2:0] c, input logic four,
                            input contacts_t k, input logic f);
        logic [31:0] e, o, m, n;
        wr(CfgOffs, 32'(c));
        wr(VariantOffs, 32'(four));
        @(posedge clk);
        want     <= k;
        wantFail <= f;
        repeat (20) @(posedge clk);
        e = 32'(expMode(c, k, four, f));
        o = 32'(modeOut);
        m = (c == 3'h7 && k.third) ? 32'hfc : 32'hff;
        n = m & 32'h63;
        chkVal("run", 32'(e[7]), 32'(o[7]));
        chkVal("mode", e & m, o & m);
        chkVal("sel", e & 32'h1c, o & 32'h1c);
        chkVal("kind", e & n, o & n);
    endtask

    task automatic speedCase(input logic [2:0] c, input logic [7:0] mn,
                             input logic [11:0] v);
        wr(CfgOffs, 32'(c));
        wr(MinFreqOffs, 32'(mn));
        @(posedge clk);
        wantVolt <= v;
        wantLoop <= v;
        repeat (4) @(posedge clk);
        chkNear("speed", expSpeed(c, v, mn), speedHz);
    endtask

    task automatic testEnd(string s);
        $display("test %s done, mismatches so far %0d", s, n_errors);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #500000;
        n_errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        int         i;
        logic [1:0] r;
        logic       a0;
        want     = '0;
        wantVolt = 12'hc00;
        wantLoop = 12'hc00;
        wantFail = 1'b0;
        {awaddr, wdata, araddr, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chkVal("ramp out", 32'h1011, 32'(rampOut));
        rdChk(CfgOffs, 2'h0, 32'h0);
        rdChk(MinFreqOffs, 2'h0, 32'h1e);
        rdChk(RampOffs, 2'h0, 32'h10808);
        rdChk(VariantOffs, 2'h0, 32'h1);
        rdChk(IrqMaskOffs, 2'h0, 32'h0);
        rdChk(8'h20, 2'h2, 32'h0);
        axWr(8'h24, 32'h1, r);
        chkVal("bresp", 32'h2, 32'(r));
        wr(RampOffs, 32'h0000_030c);
        rdChk(RampOffs, 2'h0, 32'h30c);
        chkVal("ramp out", 32'h1806, 32'(rampOut));
        testEnd("registers");
        wr(CfgOffs, 32'h0);
        @(posedge clk);
        want <= 4'hc;
        repeat (7) begin
            @(posedge clk);
            chkVal("early run", 32'h0, 32'(modeOut.runPermit));
        end
        repeat (12) @(posedge clk);
        chkVal("run", 32'h1, 32'(modeOut.runPermit));
        rdChk(StatusOffs, 2'h0, 32'h80);
        rdChk(SensorOffs, 2'h0, 32'hc);
        testEnd("debounce");
        modeCase(3'h7, 1'b1, 4'ha, 1'b0);
        modeCase(3'h3, 1'b0, 4'h8, 1'b1);
        modeCase(3'h3, 1'b1, 4'h8, 1'b0);
        for (i = 0; i < 64; i++) begin
            modeCase(i[2:0], i[3], 4'($random(seed)), 1'($random(seed)));
        end
        testEnd("modes");
        wr(MinFreqOffs, 32'h3);
        rdChk(MinFreqOffs, 2'h0, 32'h5);
        @(posedge clk);
        want <= 4'hf;
        for (i = 0; i < 24; i++) begin
            speedCase(i[4] ? 3'h7 : 3'(5 + i[3]),
                      i[2] ? 8'h1e : 8'h05, refs[i[1:0]]);
        end
        testEnd("speed");
        wr(IrqStatOffs, 32'h7);
        rdChk(IrqStatOffs, 2'h0, 32'h0);
        wr(CfgOffs, 32'h1);
        rdChk(IrqStatOffs, 2'h0, 32'h1);
        wr(IrqMaskOffs, 32'h0);
        @(posedge clk);
        a0 = irq;
        wr(IrqMaskOffs, 32'h7);
        @(posedge clk);
        chkVal("irq mask", 32'h1, 32'(a0 ^ irq));
        wr(IrqStatOffs, 32'h1);
        rdChk(IrqStatOffs, 2'h0, 32'h0);
        @(posedge clk);
        chkVal("irq", 32'h0, 32'(irq));
        testEnd("interrupt");
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
